// file: hdl/crps_top.sv
// Function
// - System reset clears the sequencer before any domain action.
// - Sideband marks each reset cold or warm; only the status and watchdog resets branch on it.
// - Per-domain setting picks powered down, clock off, or run.
// - Cold start powers exactly the cores selected to run or clock off.
// - Coherence manager powers up when any core is selected to run.
// - After rail settles, enable clock and assert reset in the same step, then run reset sequence.
// - Warm start drives every domain to its cold-start setting.
// - Isolation is raised before power is removed.
// - Warm start keeps powered run domains on, only resetting them.
// - Warm sideband picks whether status and watchdogs reset.
// - After core power-up, a test-logic reset pulses in each domain selected to run.
// - Unused cores stay powered down and isolated, not held in reset.
// - Without power gating, unused cores stay powered, clock off, isolated.
// - Per-core registers drive each core's boot vector.
// - Each core gets a distinct core number on its core_number port; the core ID register is not decoded and reads zero.
// - Core reset and root clock gating are sequence steps.
// - Micro-step and rail settle delays are parameters, 1 to 1024.
// - Default boot vector is a 4 KB aligned build-time address.
`timescale 1ns/100ps
`default_nettype none
module crps_top #(
  parameter int          NUM_CORES        = 4,
  parameter bit          POWER_GATING     = 1'b1,
  parameter int          MICRO_STEP_DELAY = crps_pkg::MICRO_STEP_CYCLES,
  parameter int          SUPPLY_SWITCH_SETTLE_DELAY = crps_pkg::RAIL_SETTLE_CYCLES,
  parameter logic [31:0] DEFAULT_BOOT     = crps_pkg::BOOT_RESET
) (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   warm_start,
  input  wire logic                   keep_cm_status,
  input  wire logic                   keep_watchdog,
  input  wire logic [7:0]             reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [31:0]            reg_rdata,
  output logic      [NUM_CORES:0]     dom_power_en,
  output logic      [NUM_CORES:0]     dom_isolate,
  output logic      [NUM_CORES:0]     dom_clk_en,
  output logic      [NUM_CORES:0]     dom_reset,
  output logic      [NUM_CORES:0]     dom_test_reset,
  output logic                        cm_status_reset,
  output logic                        watchdog_reset,
  output logic      [NUM_CORES*32-1:0] boot_vector,
  output logic      [NUM_CORES*8-1:0] core_number
);

  localparam int CW = 11;
  localparam int ND = NUM_CORES + 1;
  localparam logic [CW-1:0] STEP_CNT   = CW'(MICRO_STEP_DELAY);
  localparam logic [CW-1:0] SETTLE_CNT = CW'(SUPPLY_SWITCH_SETTLE_DELAY);
  localparam logic [CW-1:0] PULSE_CNT  = CW'(crps_pkg::RESET_PULSE_CYCLES);

  // Sequencer states, one-hot.
  typedef enum logic [8:0] {
    ST_IDLE    = 9'h001,
    ST_ISO     = 9'h002,
    ST_GATE    = 9'h004,
    ST_POWER   = 9'h008,
    ST_CLOCK   = 9'h010,
    ST_RESET   = 9'h020,
    ST_TRESET  = 9'h040,
    ST_RELEASE = 9'h080,
    ST_DONE    = 9'h100
  } crps_state_type;

  // Two-bit mode field of one domain from the mode register.
  function automatic logic [1:0] mode_of(input logic [31:0] m, input int d);
    mode_of = m[2*d +: 2];
  endfunction : mode_of

  crps_state_type state;
  crps_state_type next_state;
  logic [31:0]    mode_reg;
  logic [31:0]    next_mode_reg;
  logic [31:0]    boot_reg [NUM_CORES];
  logic [31:0]    next_boot_reg [NUM_CORES];
  logic [31:0]    next_rdata;
  logic [ND-1:0]  want_run;
  logic [ND-1:0]  want_clk;
  logic [ND-1:0]  next_power;
  logic [ND-1:0]  next_iso;
  logic [ND-1:0]  next_clk;
  logic [ND-1:0]  next_rst;
  logic [ND-1:0]  next_trst;
  logic           next_cm_rst;
  logic           next_wd_rst;
  logic           go;
  logic           next_go;
  logic [2:0]     side_sync;
  logic           is_warm;
  logic           next_is_warm;
  logic           dly_start;
  logic [CW-1:0]  dly_cycles;
  logic           dly_done;

  // All three sideband inputs come from outside the clock domain.
  crps_sync #(.W(3)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .din   ({keep_watchdog, keep_cm_status, warm_start}),
    .dout  (side_sync)
  );

  // Shared step timer for micro-steps and rail settling.
  crps_delay #(.CNT_W(CW)) u_delay (
    .clk    (clk),
    .rst_n  (rst_n),
    .start  (dly_start),
    .cycles (dly_cycles),
    .done   (dly_done)
  );

  // Wanted outcome per domain; the coherence manager is the top bit.
  always_comb
  begin
    for (int d = 0; d < NUM_CORES; d++)
    begin
      want_run[d] = (mode_of(mode_reg, d) == crps_pkg::MODE_RUN);
      want_clk[d] = (mode_of(mode_reg, d) == crps_pkg::MODE_CLK_OFF);
    end
    want_run[NUM_CORES] = |want_run[NUM_CORES-1:0];
    want_clk[NUM_CORES] = 1'b0;
  end

  // Register file writes and reads.
  always_comb
  begin
    next_mode_reg = mode_reg;
    next_go       = go;
    next_rdata    = 32'h0000_0000;
    for (int c = 0; c < NUM_CORES; c++)
    begin
      next_boot_reg[c] = boot_reg[c];
    end
    if (reg_wr)
    begin
      if (reg_addr == crps_pkg::ADDR_CTRL)
      begin
        next_go = reg_wdata[crps_pkg::CTRL_GO_BIT];
      end
      else if (reg_addr == crps_pkg::ADDR_CORE_MODE)
      begin
        next_mode_reg = reg_wdata;
      end
      for (int c = 0; c < NUM_CORES; c++)
      begin
        if (reg_addr == crps_pkg::ADDR_BOOT_BASE + 8'(4*c))
        begin
          // Low bits forced to zero keep the 4 KB alignment.
          next_boot_reg[c] = {reg_wdata[31:crps_pkg::BOOT_ALIGN],
                              {crps_pkg::BOOT_ALIGN{1'b0}}};
        end
      end
    end
    if (reg_rd)
    begin
      if (reg_addr == crps_pkg::ADDR_CTRL)
      begin
        next_rdata = {31'h0, go};
      end
      else if (reg_addr == crps_pkg::ADDR_STATUS)
      begin
        next_rdata = {16'h0000, 7'(dom_power_en), state};
      end
      else if (reg_addr == crps_pkg::ADDR_CORE_MODE)
      begin
        next_rdata = mode_reg;
      end
      for (int c = 0; c < NUM_CORES; c++)
      begin
        if (reg_addr == crps_pkg::ADDR_BOOT_BASE + 8'(4*c))
        begin
          next_rdata = boot_reg[c];
        end
      end
    end
  end

  // Sequencer: isolate, gate, power, clock, reset, test reset, release.
  always_comb
  begin
    next_state   = state;
    next_power   = dom_power_en;
    next_iso     = dom_isolate;
    next_clk     = dom_clk_en;
    next_rst     = dom_reset;
    next_trst    = dom_test_reset;
    next_cm_rst  = cm_status_reset;
    next_wd_rst  = watchdog_reset;
    next_is_warm = is_warm;
    dly_start    = 1'b0;
    dly_cycles   = STEP_CNT;
    case (state)
      ST_IDLE:
      begin
        if (go)
        begin
          next_is_warm = side_sync[0];
          next_cm_rst  = !(side_sync[0] && side_sync[1]);
          next_wd_rst  = !(side_sync[0] && side_sync[2]);
          next_state   = ST_ISO;
          dly_start    = 1'b1;
        end
      end
      ST_ISO:
      begin
        // Isolate every domain that is leaving run before touching power.
        next_iso = dom_isolate | ~want_run;
        next_clk = dom_clk_en & want_run;
        if (dly_done)
        begin
          next_state = ST_GATE;
          dly_start  = 1'b1;
        end
      end
      ST_GATE:
      begin
        next_clk = dom_clk_en & want_run;
        if (POWER_GATING)
        begin
          next_power = dom_power_en & (want_run | want_clk);
        end
        if (dly_done)
        begin
          next_state = ST_POWER;
          dly_start  = 1'b1;
          dly_cycles = SETTLE_CNT;
        end
      end
      ST_POWER:
      begin
        // Warm domains already on keep power; others switch on here.
        next_power = POWER_GATING ? (dom_power_en | want_run | want_clk)
                                  : {ND{1'b1}};
        if (dly_done)
        begin
          next_state = ST_CLOCK;
          dly_start  = 1'b1;
        end
      end
      ST_CLOCK:
      begin
        next_clk = want_run;
        next_rst = want_run;
        if (dly_done)
        begin
          next_state = ST_RESET;
          dly_start  = 1'b1;
          dly_cycles = PULSE_CNT;
        end
      end
      ST_RESET:
      begin
        if (dly_done)
        begin
          next_rst    = '0;
          next_trst   = want_run;
          next_state  = ST_TRESET;
          dly_start   = 1'b1;
          dly_cycles  = PULSE_CNT;
        end
      end
      ST_TRESET:
      begin
        if (dly_done)
        begin
          next_trst   = '0;
          next_cm_rst = 1'b0;
          next_wd_rst = 1'b0;
          next_state  = ST_RELEASE;
          dly_start   = 1'b1;
        end
      end
      ST_RELEASE:
      begin
        if (dly_done)
        begin
          next_iso   = ~want_run;
          next_state = ST_DONE;
        end
      end
      ST_DONE:
      begin
        if (!go)
        begin
          next_state = ST_IDLE;
        end
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Register stage; reset puts all domains unclocked and isolated, and unpowered when gated.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state           <= ST_IDLE;
      mode_reg        <= crps_pkg::MODE_RESET;
      go              <= 1'b0;
      is_warm         <= 1'b0;
      reg_rdata       <= 32'h0000_0000;
      dom_power_en    <= POWER_GATING ? '0 : {ND{1'b1}};
      dom_isolate     <= {ND{1'b1}};
      dom_clk_en      <= '0;
      dom_reset       <= '0;
      dom_test_reset  <= '0;
      cm_status_reset <= 1'b0;
      watchdog_reset  <= 1'b0;
      for (int c = 0; c < NUM_CORES; c++)
      begin
        boot_reg[c] <= DEFAULT_BOOT;
      end
    end
    else
    begin
      state           <= next_state;
      mode_reg        <= next_mode_reg;
      go              <= next_go;
      is_warm         <= next_is_warm;
      reg_rdata       <= next_rdata;
      dom_power_en    <= next_power;
      dom_isolate     <= next_iso;
      dom_clk_en      <= next_clk;
      dom_reset       <= next_rst;
      dom_test_reset  <= next_trst;
      cm_status_reset <= next_cm_rst;
      watchdog_reset  <= next_wd_rst;
      for (int c = 0; c < NUM_CORES; c++)
      begin
        boot_reg[c] <= next_boot_reg[c];
      end
    end
  end

  // Boot vectors and distinct core numbers straight from flip-flops.
  always_ff @(posedge clk)
  begin
    for (int c = 0; c < NUM_CORES; c++)
    begin
      boot_vector[32*c +: 32] <= boot_reg[c];
      core_number[8*c +: 8]   <= 8'(c);
    end
  end

  // Power never drops while the domain is not isolated.
  AST_ISO_BEFORE_OFF: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(dom_power_en[0]) |-> $past(dom_isolate[0]))
    else $error("power removed without isolation");
  AST_RESET_IDLE: assert property (@(posedge clk)
    !rst_n |=> state == ST_IDLE)
    else $error("sequencer not idle after reset");
  // Checked on entry to done, since software may rewrite the mode register while done.
  AST_CM_FOLLOWS: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(state == ST_DONE) |->
      dom_power_en[NUM_CORES] == (|want_run[NUM_CORES-1:0] | !POWER_GATING))
    else $error("coherence manager power wrong");
  AST_EXACT_RUN: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(state == ST_DONE) |-> dom_clk_en == want_run)
    else $error("running set differs from selection");
  AST_CLK_BEFORE_RESET: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(dom_reset[0]) |-> dom_clk_en[0] || $rose(dom_clk_en[0]))
    else $error("reset without clock");
  AST_ISO_LATE: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(dom_isolate[0]) |-> dom_clk_en[0] && !dom_reset[0])
    else $error("isolation released early");
  AST_TRST_AFTER: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(dom_test_reset[0]) |-> $past(state == ST_RESET))
    else $error("test reset out of order");
  AST_UNUSED_ISO: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(state == ST_DONE) && !want_run[0] |-> dom_isolate[0] && !dom_clk_en[0])
    else $error("unused core not isolated");
  COV_DONE: cover property (@(posedge clk) state == ST_DONE);
  COV_WARM: cover property (@(posedge clk) state == ST_ISO && is_warm);
  COV_TRST: cover property (@(posedge clk) $rose(dom_test_reset[0]));

endmodule : crps_top
`default_nettype wire

// file: hdl/crps_pkg.sv
package crps_pkg;

  // Register offsets (byte addresses, one word each).
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_STATUS    = 8'h04;
  localparam logic [7:0] ADDR_CORE_MODE = 8'h08;
  localparam logic [7:0] ADDR_CORE_ID   = 8'h0C;
  localparam logic [7:0] ADDR_BOOT_BASE = 8'h40;

  // Control register field positions.
  localparam int CTRL_GO_BIT = 0;

  // Per-domain mode codes held in the mode register, two bits per core.
  localparam logic [1:0] MODE_OFF      = 2'h0;
  localparam logic [1:0] MODE_CLK_OFF  = 2'h1;
  localparam logic [1:0] MODE_RUN      = 2'h2;

  // Reset values.
  localparam logic [31:0] MODE_RESET   = 32'h0000_0000;
  localparam logic [31:0] BOOT_RESET   = 32'hBFC0_0000;
  localparam int          BOOT_ALIGN   = 12;

  // Timing: delays given in cycles, default values.
  localparam int MICRO_STEP_CYCLES  = 4;
  localparam int RAIL_SETTLE_CYCLES = 16;
  localparam int DELAY_MAX_CYCLES   = 1024;
  localparam int RESET_PULSE_CYCLES = 2;

endpackage : crps_pkg

// file: hdl/crps_delay.sv
`timescale 1ns/100ps
`default_nettype none
// Counts a programmed number of cycles after a start pulse and flags done.
module crps_delay #(
  parameter int CNT_W = 11
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             start,
  input  wire logic [CNT_W-1:0] cycles,
  output logic                  done
);

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic             busy;
  logic             next_busy;
  logic             next_done;

  // Next count: load on start, then decrement to one and raise done.
  always_comb
  begin
    next_count = count;
    next_busy  = busy;
    next_done  = 1'b0;
    if (start)
    begin
      next_count = cycles;
      next_busy  = 1'b1;
    end
    else if (busy)
    begin
      if (count <= {{(CNT_W-1){1'b0}}, 1'b1})
      begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end
      else
      begin
        next_count = count - {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // Register stage.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      count <= '0;
      busy  <= 1'b0;
      done  <= 1'b0;
    end
    else
    begin
      count <= next_count;
      busy  <= next_busy;
      done  <= next_done;
    end
  end

endmodule : crps_delay
`default_nettype wire

// file: hdl/crps_sync.sv
`timescale 1ns/100ps
`default_nettype none
// Three-stage synchroniser; a change counts once stages two and three agree.
module crps_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_dout;

  // Accept a new level only when the last two stages match.
  always_comb
  begin
    next_dout = dout;
    for (int i = 0; i < W; i++)
    begin
      if (s2[i] == s3[i])
      begin
        next_dout[i] = s3[i];
      end
    end
  end

  // Shift chain.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s1   <= '0;
      s2   <= '0;
      s3   <= '0;
      dout <= '0;
    end
    else
    begin
      s1   <= din;
      s2   <= s1;
      s3   <= s2;
      dout <= next_dout;
    end
  end

endmodule : crps_sync
`default_nettype wire

// file: test/crps_dom_model.sv
`timescale 1ns/100ps
`default_nettype none
// Behavioural power domains: rails ramp after enable and misuse is counted.
module crps_dom_model #(
  parameter int NDOM   = 5,
  parameter int SETTLE = 16
) (
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire logic [NDOM-1:0] power_en,
  input  wire logic [NDOM-1:0] isolate,
  input  wire logic [NDOM-1:0] clk_en,
  output logic      [NDOM-1:0] rail_ok,
  output logic      [7:0]      errs
);
  int          cnt [NDOM];
  logic [NDOM-1:0] prev_pwr;
  logic [NDOM-1:0] prev_iso;
  logic            prev_rst;

  // Each rail counts up after its enable and reads nominal half way to the settle time.
  always @(posedge clk)
  begin
    if (!rst_n)
      errs <= 8'h00;
    for (int d = 0; d < NDOM; d++)
    begin
      cnt[d]     <= power_en[d] ? ((cnt[d] < SETTLE) ? cnt[d] + 1 : cnt[d]) : 0;
      rail_ok[d] <= power_en[d] && (cnt[d] >= SETTLE / 2);
      if (rst_n && prev_rst)
      begin
        if (clk_en[d] && !rail_ok[d]) errs <= errs + 8'h01;
        if (prev_pwr[d] && !power_en[d] && !(prev_iso[d] && isolate[d])) errs <= errs + 8'h01;
        if (prev_iso[d] && !isolate[d] && !clk_en[d]) errs <= errs + 8'h01;
      end
    end
    prev_pwr <= power_en;
    prev_iso <= isolate;
    prev_rst <= rst_n;
  end
endmodule : crps_dom_model
`default_nettype wire

// file: test/tb_cluster_reset_power_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e, m) begin checks_done++; if ((g) !== (e)) begin mismatches++; $display("wrong value at %0t: %s", $time, m); end end
module tb_cluster_reset_power_sequencer;
  localparam int NC = 4;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} crps_row_type;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              warm_start = 1'b0;
  logic              keep_cm_status = 1'b0;
  logic              keep_watchdog = 1'b0;
  logic [7:0]        reg_addr = 8'h00;
  logic [31:0]       reg_wdata = 32'h0;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [31:0]       reg_rdata;
  logic [NC:0]       dom_power_en, dom_isolate, dom_clk_en, dom_reset, dom_test_reset;
  logic              cm_status_reset, watchdog_reset;
  logic [NC*32-1:0]  boot_vector;
  logic [NC*8-1:0]   core_number;
  logic [7:0]        errs;
  logic [NC:0]       ng_power, ng_isolate, ng_clk;
  logic [NC:0]       seen_tr, seen_rst, pwr_q;
  logic              seen_cms, seen_wd, drop3;
  logic              clr = 1'b1;
  logic [31:0]       d;
  int                mismatches = 0;
  int                checks_done = 0;
  crps_row_type      rows [7] = '{'{8'h08, 32'h86, 32'h86}, '{8'h40, 32'h1000_0ABC, 32'h1000_0000},
    '{8'h44, 32'h2000_1FFF, 32'h2000_1000}, '{8'h48, 32'hFFFF_FFFF, 32'hFFFF_F000},
    '{8'h4C, 32'h0, 32'h0}, '{8'h0C, 32'hFFFF_FFFF, 32'h0}, '{8'h80, 32'hFFFF_FFFF, 32'h0}};

  // Clock of 10 ns period.
  always #5 clk = ~clk;

  crps_top #(.NUM_CORES(NC)) DUT (.clk(clk), .rst_n(rst_n), .warm_start(warm_start),
    .keep_cm_status(keep_cm_status), .keep_watchdog(keep_watchdog), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .dom_power_en(dom_power_en), .dom_isolate(dom_isolate), .dom_clk_en(dom_clk_en),
    .dom_reset(dom_reset), .dom_test_reset(dom_test_reset), .cm_status_reset(cm_status_reset),
    .watchdog_reset(watchdog_reset), .boot_vector(boot_vector), .core_number(core_number));

  // Second build without power gating, fed the same stimulus.
  crps_top #(.NUM_CORES(NC), .POWER_GATING(1'b0)) DUT_NOGATE (.clk(clk), .rst_n(rst_n),
    .warm_start(warm_start), .keep_cm_status(keep_cm_status), .keep_watchdog(keep_watchdog),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(),
    .dom_power_en(ng_power), .dom_isolate(ng_isolate), .dom_clk_en(ng_clk), .dom_reset(),
    .dom_test_reset(), .cm_status_reset(), .watchdog_reset(), .boot_vector(), .core_number());

  crps_dom_model #(.NDOM(NC + 1), .SETTLE(crps_pkg::RAIL_SETTLE_CYCLES)) u_domains (
    .clk(clk), .rst_n(rst_n), .power_en(dom_power_en), .isolate(dom_isolate),
    .clk_en(dom_clk_en), .rail_ok(), .errs(errs));

  // Records which sequence pulses appeared and whether core three ever lost power.
  always @(posedge clk)
  begin
    pwr_q <= dom_power_en;
    if (clr)
    begin
      seen_tr <= '0;
      seen_rst <= '0;
      seen_cms <= 1'b0;
      seen_wd <= 1'b0;
      drop3 <= 1'b0;
    end
    else
    begin
      seen_tr <= seen_tr | dom_test_reset;
      seen_rst <= seen_rst | dom_reset;
      seen_cms <= seen_cms | cm_status_reset;
      seen_wd <= seen_wd | watchdog_reset;
      drop3 <= drop3 | (pwr_q[3] & ~dom_power_en[3]);
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= w;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 r = reg_rdata;
  endtask : rd

  // Waits under a bound until the masked clock enables and isolation reach their final values.
  task automatic settle(input logic [NC:0] m, input logic [NC:0] ce, input logic [NC:0] iso);
    int n;
    n = 0;
    while (((dom_clk_en & m) !== ce || (dom_isolate & m) !== iso) && n < 500)
    begin
      @(posedge clk);
      n++;
    end
    `CHK(n < 500, 1'b1, "sequence did not finish")
    repeat (4) @(posedge clk);
  endtask : settle

  task automatic chk_rst();
    `CHK(dom_power_en, 5'b00000, "power after reset")
    `CHK(dom_isolate, 5'b11111, "isolation after reset")
    `CHK(dom_clk_en | dom_reset, 5'b00000, "clock or reset after reset")
    `CHK({ng_power, ng_isolate, ng_clk}, 15'h7FE0, "ungated reset state")
    for (int c = 0; c < NC; c++)
    begin
      `CHK(boot_vector[c*32+:32], crps_pkg::BOOT_RESET, "boot vector reset")
      `CHK(core_number[c*8+:8], 8'(c), "core number")
    end
    rd(crps_pkg::ADDR_CORE_MODE, d);
    `CHK(d, crps_pkg::MODE_RESET, "mode reset value")
  endtask : chk_rst

  task automatic give_verdict();
    if (mismatches == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  // Cuts a hung run short.
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    give_verdict();
  end

  // Register table, then cold start, warm start and a reset in mid-sequence.
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    clr <= 1'b0;
    chk_rst();
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, d);
      `CHK(d, rows[i].e, "register readback")
    end
    for (int c = 0; c < NC; c++)
      `CHK(boot_vector[c*32+:32], rows[c+1].e, "boot vector port")
    wr(crps_pkg::ADDR_CTRL, 32'h1);
    settle(5'b11101, 5'b11001, 5'b00100);
    `CHK(dom_power_en & 5'b11101, 5'b11001, "cold power set")
    `CHK(dom_clk_en[1], 1'b0, "clock-off core clocked")
    `CHK({ng_power, ng_isolate, ng_clk}, {5'b11111, 5'b00110, 5'b11001}, "ungated cold")
    `CHK(seen_tr & 5'b11001, 5'b11001, "test reset pulses")
    `CHK(seen_rst & 5'b11001, 5'b11001, "reset pulses")
    `CHK(seen_cms, 1'b1, "cold status reset")
    warm_start <= 1'b1;
    keep_cm_status <= 1'b1;
    clr <= 1'b1;
    wr(crps_pkg::ADDR_CORE_MODE, 32'h88);
    clr <= 1'b0;
    wr(crps_pkg::ADDR_CTRL, 32'h0);
    wr(crps_pkg::ADDR_CTRL, 32'h1);
    settle(5'b11111, 5'b11010, 5'b00101);
    `CHK(dom_power_en, 5'b11010, "warm power set")
    `CHK({ng_power, ng_isolate, ng_clk}, {5'b11111, 5'b00101, 5'b11010}, "ungated warm")
    `CHK({drop3, seen_rst[3]}, 2'b01, "warm run core kept power")
    `CHK({seen_cms, seen_wd}, 2'b01, "warm keep sideband")
    warm_start <= 1'b0;
    wr(crps_pkg::ADDR_CTRL, 32'h0);
    wr(crps_pkg::ADDR_CTRL, 32'h1);
    repeat (6) @(posedge clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    chk_rst();
    `CHK(errs, 8'h00, "domain misuse")
    give_verdict();
  end
endmodule : tb_cluster_reset_power_sequencer
`default_nettype wire
